// ==== common/sfps_defs.vh ====
// Opcodes, status bit positions and timing figures of the write-type flash sequencer
`ifndef SFPS_DEFS_VH
`define SFPS_DEFS_VH

// Command opcodes
`define SFPS_OP_WREN 8'h06
`define SFPS_OP_WRDI 8'h04
`define SFPS_OP_VWREN 8'h50
`define SFPS_OP_WRSR 8'h01
`define SFPS_OP_RDSR1 8'h05
`define SFPS_OP_PP 8'h02
`define SFPS_OP_SE 8'h20
`define SFPS_OP_BE 8'hD8
`define SFPS_OP_CE1 8'hC7
`define SFPS_OP_CE2 8'h60

// Status register one bit positions
`define SFPS_SR1_BUSY 0
`define SFPS_SR1_WEL 1
`define SFPS_SR1_BP_LO 2
`define SFPS_SR1_BP_HI 4
`define SFPS_SR1_TB 5
`define SFPS_SR1_SEC 6
`define SFPS_SR1_STATUS_LOCK_SELECT_LOW 7

// Status register two bit positions
`define SFPS_SR2_STATUS_LOCK_SELECT_HIGH 0
`define SFPS_SR2_QE 1
`define SFPS_SR2_LB_LO 2
`define SFPS_SR2_LB_HI 5
`define SFPS_SR2_CMP 6

// Reset values of the three status registers
`define SFPS_SR1_RST 8'h00
`define SFPS_SR2_RST 8'h00
`define SFPS_SR3_RST 8'h00

// Byte count of the address frame, opcode included, and data bytes in one page
`define SFPS_ADDR_FRAME 4
`define SFPS_PAGE_BYTES 256

// Clock rate and self-timed durations in microseconds
`define SFPS_CLK_MHZ 100
`define SFPS_STATUS_WRITE_US 10000
`define SFPS_PAGE_PROGRAM_US 700
`define SFPS_SECTOR_ERASE_US 100000
`define SFPS_BLOCK_ERASE_US 500000
`define SFPS_CHIP_ERASE_US 10000000

// Cycle counts derived from the durations
`define SFPS_STATUS_WRITE_CYC (`SFPS_STATUS_WRITE_US * `SFPS_CLK_MHZ)
`define SFPS_PAGE_PROGRAM_CYC (`SFPS_PAGE_PROGRAM_US * `SFPS_CLK_MHZ)
`define SFPS_SECTOR_ERASE_CYC (`SFPS_SECTOR_ERASE_US * `SFPS_CLK_MHZ)
`define SFPS_BLOCK_ERASE_CYC (`SFPS_BLOCK_ERASE_US * `SFPS_CLK_MHZ)
`define SFPS_CHIP_ERASE_CYC (`SFPS_CHIP_ERASE_US * `SFPS_CLK_MHZ)

`endif

// ==== verification/sfps_core_chk.sv ====
// Port assertions of the flash write sequencer
`timescale 1ns/1ps
module sfps_core_chk (
    input wire clock_i,
    input wire reset_n_i,
    input wire prog_ready_i,
    input wire [7:0] status_reg_one_o,
    input wire [7:0] status_reg_two_o,
    input wire [7:0] status_reg_three_o,
    input wire prog_valid_o,
    input wire [23:0] prog_addr_o,
    input wire [7:0] prog_data_o,
    input wire erase_start_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // Busy and latch bits of status one
    wire busy = status_reg_one_o[0];
    wire write_enable_latch = status_reg_one_o[1];
    chk_erase_in_busy: assert property (erase_start_o |-> busy && write_enable_latch)
        else $error("erase launched outside a busy cycle");
    chk_erase_one_pulse: assert property (erase_start_o |=> !erase_start_o)
        else $error("erase start longer than one cycle");
    chk_busy_needs_wel: assert property ($rose(busy) |-> write_enable_latch)
        else $error("timed cycle began without the latch");
    chk_busy_end_wel: assert property ($fell(busy) |-> !write_enable_latch)
        else $error("latch left set after the timed cycle");
    chk_busy_min_len: assert property ($rose(busy) |-> busy [*8])
        else $error("busy cycle too short");
    // Lock bits only rise; a reset is the sole way back
    chk_lock_sticky: assert property ((($past(status_reg_two_o[5:2]) & ~status_reg_two_o[5:2]) == 4'h0))
        else $error("lock bit returned to zero");
    chk_reserved_zero: assert property (!status_reg_two_o[7] && !status_reg_three_o[7])
        else $error("read-only status bit changed");
    chk_prog_hold: assert property (prog_valid_o && !prog_ready_i |=> prog_valid_o && $stable(prog_data_o) && $stable(prog_addr_o))
        else $error("program byte changed while stalled");
    chk_prog_in_busy: assert property (prog_valid_o |-> busy)
        else $error("program byte outside a busy cycle");
    chk_prog_same_page: assert property (prog_valid_o && prog_ready_i ##1 prog_valid_o |-> prog_addr_o[23:8] == $past(prog_addr_o[23:8]))
        else $error("program stream left its page");
    cov_erase: cover property (erase_start_o);
    cov_busy_end: cover property ($fell(busy));
    cov_stall: cover property (prog_valid_o && !prog_ready_i);
endmodule

// ==== verification/sfps_host.sv ====
// Host SPI master model in mode 0; its clock stands still between frames
`timescale 1ns/1ps
module sfps_host (
    input wire logic clock_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    input wire logic so_i
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    task automatic open();
        @(negedge clock_i);
        cs_n_o = 1'b0;
        #80;
    endtask
    // Shift n bits MSB first; data moves only while the clock is low
    task automatic put(input logic [7:0] d, input int n, output logic [7:0] r);
        for (int i = 7; i > 7 - n; i--) begin
            si_o = d[i];
            #80 sck_o = 1'b1;
            r = {r[6:0], so_i};
            #80 sck_o = 1'b0;
        end
    endtask
    // Released data line shows the inverse so a stale level cannot pass
    task automatic close();
        #80 cs_n_o = 1'b1;
        si_o = ~si_o;
        #400;
    endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench of the flash write sequencer
`timescale 1ns/1ps
`include "sfps_defs.vh"
module testbench;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic prog_ready = 1'b0;
    wire cs_n, sck, si, so, pv, es;
    wire [7:0] sr1, sr2, sr3, pd;
    wire [23:0] pa, ea;
    wire [1:0] ek;
    int mismatches = 0;
    int total_checks = 0;
    int nerase = 0;
    int nb;
    logic [7:0] img [0:255];
    logic [31:0] got [$];
    logic [7:0] v1, v2, v3, lk, op, o, st, r;
    logic [23:0] a;
    logic f;
    logic [1:0] kinds [4] = '{2'd0, 2'd1, 2'd2, 2'd2};
    logic [7:0] ops [4] = '{`SFPS_OP_SE, `SFPS_OP_BE, `SFPS_OP_CE1, `SFPS_OP_CE2};
    always #5 clock_i = ~clock_i;
    sfps_host host (.clock_i(clock_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so));
    sfps_core #(.STATUS_WRITE_CYC(400), .PAGE_PROGRAM_CYC(600), .SECTOR_ERASE_CYC(1500),
        .BLOCK_ERASE_CYC(1600), .CHIP_ERASE_CYC(1700)) dut (.clock_i(clock_i),
        .reset_n_i(reset_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(),
        .status_reg_one_o(sr1), .status_reg_two_o(sr2), .status_reg_three_o(sr3),
        .prog_valid_o(pv), .prog_ready_i(prog_ready), .prog_addr_o(pa), .prog_data_o(pd),
        .erase_start_o(es), .erase_kind_o(ek), .erase_addr_o(ea));
    // Record array traffic; the ready line stalls at random to fill the FIFO
    always @(posedge clock_i) begin
        if (pv && prog_ready) got.push_back({pa, pd});
        if (es) nerase++;
    end
    always @(negedge clock_i) prog_ready <= reset_n_i && $urandom_range(3) != 0;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic send(input logic [31:0] d, input int nbits);
        host.open();
        for (int k = 0; k < nbits; k += 8) host.put(d[31-k -: 8], (nbits - k > 8) ? 8 : nbits - k, r);
        host.close();
    endtask
    task automatic rdsr(output logic [7:0] s);
        host.open();
        host.put(`SFPS_OP_RDSR1, 8, s);
        host.put(8'h00, 8, s);
        host.close();
    endtask
    // Poll busy through the status read, first answer returned
    task automatic idle(output logic fb);
        logic [7:0] s;
        int n;
        n = 0;
        rdsr(s);
        fb = s[0];
        while (s[0] !== 1'b0 && n < 60) begin
            rdsr(s);
            n++;
        end
        chk("idle", 32'h0, {31'h0, s[0]});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #1500000;
        mismatches++;
        test_done();
    end
    initial begin
        void'($urandom(32'h29B3));
        repeat (3) @(negedge clock_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        rdsr(v1);
        chk("sr1 reset", 8'h00, v1);
        send({`SFPS_OP_WRSR, 8'h7C, 16'h0}, 16);
        chk("sr1 no latch", 8'h00, sr1);
        send({`SFPS_OP_WREN, 24'h0}, 8);
        chk("latch set", 8'h02, sr1);
        send({`SFPS_OP_WRDI, 24'h0}, 8);
        chk("latch clear", 8'h00, sr1);
        // Random write, then all zeros: set lock bits must survive
        for (int t = 0; t < 2; t++) begin
            v1 = t ? 8'h00 : 8'($urandom) & 8'h7C;
            v2 = t ? 8'h00 : 8'($urandom) & 8'h7E;
            v3 = t ? 8'h00 : 8'($urandom) & 8'h7F;
            lk = sr2 & 8'h3C;
            send({`SFPS_OP_WREN, 24'h0}, 8);
            send({`SFPS_OP_WRSR, v1, v2, v3}, 32);
            idle(f);
            chk("nv busy", 32'h1, {31'h0, f});
            chk("nv sr1", v1, sr1);
            chk("nv sr2", v2 | lk, sr2);
            chk("nv sr3", v3, sr3);
        end
        $display("test status write done");
        lk = sr2 & 8'h3C;
        send({`SFPS_OP_VWREN, 24'h0}, 8);
        send({`SFPS_OP_WRSR, 8'h00, 8'h7F, 8'h55}, 32);
        chk("vol sr2", 8'h42 | lk, sr2);
        chk("vol sr1", 8'h00, sr1);
        send({`SFPS_OP_VWREN, 24'h0}, 8);
        send({`SFPS_OP_WRSR, 8'h04, 16'h0}, 16);
        chk("one byte sr2", lk, sr2);
        chk("one byte sr3", 8'h55, sr3);
        chk("one byte sr1", 8'h04, sr1);
        // Top block now protected: erases there are refused
        send({`SFPS_OP_WREN, 24'h0}, 8);
        send({`SFPS_OP_SE, 24'h3FF000}, 32);
        send({`SFPS_OP_CE1, 24'h0}, 8);
        chk("prot erase", 32'h0, nerase);
        chk("prot sr1", 8'h06, sr1);
        send({`SFPS_OP_WRDI, 24'h0}, 8);
        send({`SFPS_OP_VWREN, 24'h0}, 8);
        send({`SFPS_OP_WRSR, 8'h00, 16'h0}, 16);
        send({`SFPS_OP_WREN, 24'h0}, 8);
        send({`SFPS_OP_WRSR, 8'h1C, 8'h00, 4'h0, 4'h0}, 20);
        send({`SFPS_OP_SE, 24'h001000}, 28);
        chk("partial byte", 8'h02, sr1);
        chk("partial erase", 32'h0, nerase);
        $display("test protection done");
        for (int k = 0; k < 4; k++) begin
            op = ops[k];
            a = 24'($urandom) & (k ? 24'h3F0000 : 24'h3FF000);
            send({`SFPS_OP_WREN, 24'h0}, 8);
            send({op, a}, k < 2 ? 32 : 8);
            send({op, a}, k < 2 ? 32 : 8);
            idle(f);
            chk("erase busy", 32'h1, {31'h0, f});
            chk("erase count", k + 1, nerase);
            chk("erase kind", kinds[k], ek);
            if (k < 2) chk("erase addr", a, ea);
            chk("erase sr1", 8'h00, sr1);
        end
        $display("test erase done");
        for (int k = 0; k < 3; k++) begin
            nb = k ? $urandom_range(1, 20) : 260;
            a = {2'b00, 14'($urandom), k ? 8'hF8 : 8'h10};
            got.delete();
            if (k < 2) send({`SFPS_OP_WREN, 24'h0}, 8);
            host.open();
            host.put(`SFPS_OP_PP, 8, r);
            for (int j = 2; j >= 0; j--) host.put(a[8*j +: 8], 8, r);
            for (int i = 0; i < nb; i++) begin
                o = a[7:0] + 8'(i);
                img[o] = 8'($urandom);
                host.put(img[o], 8, r);
            end
            host.close();
            idle(f);
            st = nb >= 256 ? 8'h00 : a[7:0];
            nb = k == 2 ? 0 : (nb > 256 ? 256 : nb);
            chk("prog count", nb, got.size());
            for (int i = 0; i < nb && i < got.size(); i++) begin
                o = st + 8'(i);
                chk("prog byte", {a[23:8], o, img[o]}, got[i]);
            end
            chk("prog sr1", 8'h00, sr1);
        end
        $display("test program done");
        test_done();
    end
endmodule
bind sfps_core sfps_core_chk u_chk (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .prog_ready_i(prog_ready_i), .status_reg_one_o(status_reg_one_o),
    .status_reg_two_o(status_reg_two_o), .status_reg_three_o(status_reg_three_o),
    .prog_valid_o(prog_valid_o), .prog_addr_o(prog_addr_o), .prog_data_o(prog_data_o),
    .erase_start_o(erase_start_o));

// ==== verilog/sfps_core.v ====
// Write-type command sequencer of a serial flash, with its program data FIFO
`timescale 1ns/1ps
`include "sfps_defs.vh"

// Synchronous FIFO between page buffer and the array programming port
module sfps_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clock_i,
    input wire reset_n_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    wire empty = (wr_ptr_reg == rd_ptr_reg);

    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = mem_reg[rd_ptr_reg[AW-1:0]];

    // Pointers carry one extra wrap bit so full and empty stay distinct
    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid_i && !full) begin
                mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (out_ready_i && !empty)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule

module sfps_core #(
    parameter MEM_ADDR_W = 22,
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW = 5,
    parameter STATUS_WRITE_CYC = `SFPS_STATUS_WRITE_CYC,
    parameter PAGE_PROGRAM_CYC = `SFPS_PAGE_PROGRAM_CYC,
    parameter SECTOR_ERASE_CYC = `SFPS_SECTOR_ERASE_CYC,
    parameter BLOCK_ERASE_CYC = `SFPS_BLOCK_ERASE_CYC,
    parameter CHIP_ERASE_CYC = `SFPS_CHIP_ERASE_CYC
) (
    input wire clock_i,
    input wire reset_n_i,
    input wire cs_n_i,
    input wire sck_i,
    input wire si_i,
    output reg so_o,
    output wire so_oe_o,
    output wire [7:0] status_reg_one_o,
    output wire [7:0] status_reg_two_o,
    output wire [7:0] status_reg_three_o,
    output wire prog_valid_o,
    input wire prog_ready_i,
    output wire [23:0] prog_addr_o,
    output wire [7:0] prog_data_o,
    output reg erase_start_o,
    output reg [1:0] erase_kind_o,
    output reg [23:0] erase_addr_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_STREAM = 2'd1;
    localparam ST_WAIT = 2'd2;
    localparam [1:0] KIND_SECTOR = 2'd0;
    localparam [1:0] KIND_BLOCK = 2'd1;
    localparam [1:0] KIND_CHIP = 2'd2;
    localparam [23:0] MEM_MASK = ({24{1'b1}} >> (24 - MEM_ADDR_W));
    localparam [7:0] SR1_RST = `SFPS_SR1_RST;
    localparam [7:0] SR2_RST = `SFPS_SR2_RST;
    localparam [7:0] SR3_RST = `SFPS_SR3_RST;

    // Two-stage synchronisers; the third sck and cs flops only feed edge detection
    reg cs_s1_reg, cs_s2_reg, cs_d_reg;
    reg sck_s1_reg, sck_s2_reg, sck_d_reg;
    reg si_s1_reg, si_s2_reg;
    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_d_reg <= 1'b1;
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_d_reg <= 1'b0;
            si_s1_reg <= 1'b0;
            si_s2_reg <= 1'b0;
        end else begin
            cs_s1_reg <= cs_n_i;
            cs_s2_reg <= cs_s1_reg;
            cs_d_reg <= cs_s2_reg;
            sck_s1_reg <= sck_i;
            sck_s2_reg <= sck_s1_reg;
            sck_d_reg <= sck_s2_reg;
            si_s1_reg <= si_i;
            si_s2_reg <= si_s1_reg;
        end
    end

    wire sck_rise = sck_s2_reg & ~sck_d_reg & ~cs_s2_reg;
    wire sck_fall = ~sck_s2_reg & sck_d_reg & ~cs_s2_reg;
    wire cs_fall = ~cs_s2_reg & cs_d_reg;
    wire cs_rise = cs_s2_reg & ~cs_d_reg;

    // Command shifter state
    reg [2:0] bit_cnt_reg;
    reg [6:0] shift_reg;
    reg [9:0] byte_idx_reg;
    reg [7:0] opcode_reg;
    reg [23:0] addr_reg;
    reg [7:0] wdata1_reg, wdata2_reg, wdata3_reg;
    reg [8:0] pp_cnt_reg;
    reg [7:0] pbuf_reg [0:`SFPS_PAGE_BYTES-1];
    wire byte_done = sck_rise && (bit_cnt_reg == 3'd7);
    wire [7:0] new_byte = {shift_reg, si_s2_reg};

    // Status bits and sequencer state
    reg [7:2] sr1_reg;
    reg [6:0] sr2_reg;
    reg [6:0] sr3_reg;
    reg wel_reg, vol_arm_reg;
    reg [1:0] state_reg;
    reg [31:0] timer_reg;
    reg nv_pend_reg;
    reg [7:0] pend1_reg, pend2_reg, pend3_reg;
    reg [8:0] str_idx_reg;
    reg [8:0] str_len_reg;
    reg [7:0] str_start_reg;
    reg [15:0] str_page_reg;
    wire busy = (state_reg != ST_IDLE);

    assign status_reg_one_o = {sr1_reg, wel_reg, busy};
    assign status_reg_two_o = {1'b0, sr2_reg};
    assign status_reg_three_o = {1'b0, sr3_reg};

    // Protected-range test from the current protection bits
    function prot_hit;
        input [23:0] a;
        integer sl;
        reg [2:0] bp;
        reg [23:0] hi;
        reg inr;
        begin
            bp = sr1_reg[`SFPS_SR1_BP_HI:`SFPS_SR1_BP_LO];
            if (sr1_reg[`SFPS_SR1_SEC])
                sl = 11 + ((bp > 3'd4) ? 4 : bp);
            else
                sl = 15 + bp;
            hi = (a & MEM_MASK) >> sl;
            if (sr1_reg[`SFPS_SR1_TB])
                inr = (hi == 24'h000000);
            else
                inr = (hi == (MEM_MASK >> sl));
            if (bp == 3'd0)
                prot_hit = sr2_reg[`SFPS_SR2_CMP];
            else
                prot_hit = inr ^ sr2_reg[`SFPS_SR2_CMP];
        end
    endfunction

    // Chip erase needs every page unprotected
    reg any_prot;
    reg [2:0] bp_cur;
    always @* begin
        bp_cur = sr1_reg[`SFPS_SR1_BP_HI:`SFPS_SR1_BP_LO];
        if (bp_cur == 3'd0)
            any_prot = sr2_reg[`SFPS_SR2_CMP];
        else if (sr2_reg[`SFPS_SR2_CMP])
            any_prot = ~(prot_hit(24'h000000) & prot_hit(MEM_MASK)) |
                       (prot_hit(24'h000000) ^ prot_hit(MEM_MASK)) |
                       prot_hit(24'h000000);
        else
            any_prot = 1'b1;
    end

    // New status values from the data bytes of a status write
    reg [9:0] nbytes;
    reg [7:2] sr1_new;
    reg [6:0] sr2_new;
    reg [6:0] sr3_new;
    always @* begin
        nbytes = byte_idx_reg - 10'd1;
        sr1_new = wdata1_reg[7:2];
        sr2_new = sr2_reg;
        sr3_new = sr3_reg;
        if (nbytes == 10'd1) begin
            if (!sr2_reg[`SFPS_SR2_STATUS_LOCK_SELECT_HIGH]) begin
                sr2_new[`SFPS_SR2_CMP] = 1'b0;
                sr2_new[`SFPS_SR2_QE] = 1'b0;
            end
        end else begin
            sr2_new = wdata2_reg[6:0];
            sr2_new[`SFPS_SR2_LB_HI:`SFPS_SR2_LB_LO] =
                sr2_reg[`SFPS_SR2_LB_HI:`SFPS_SR2_LB_LO] |
                wdata2_reg[`SFPS_SR2_LB_HI:`SFPS_SR2_LB_LO];
            if (vol_arm_reg) begin
                sr2_new[`SFPS_SR2_LB_HI:`SFPS_SR2_LB_LO] =
                    sr2_reg[`SFPS_SR2_LB_HI:`SFPS_SR2_LB_LO];
                sr2_new[`SFPS_SR2_STATUS_LOCK_SELECT_HIGH] = sr2_reg[`SFPS_SR2_STATUS_LOCK_SELECT_HIGH];
            end
        end
        if (nbytes == 10'd3)
            sr3_new = wdata3_reg[6:0];
    end

    // Command frame decode at chip select rise
    wire frame_whole = cs_rise && (bit_cnt_reg == 3'd0) && (byte_idx_reg != 10'd0);
    wire is_op1 = (byte_idx_reg == 10'd1);
    wire is_addr = (byte_idx_reg == `SFPS_ADDR_FRAME);
    wire do_wren = frame_whole && !busy && is_op1 && (opcode_reg == `SFPS_OP_WREN);
    wire do_wrdi = frame_whole && !busy && is_op1 && (opcode_reg == `SFPS_OP_WRDI);
    wire do_varm = frame_whole && !busy && is_op1 && (opcode_reg == `SFPS_OP_VWREN);
    wire wrsr_ok = frame_whole && !busy && (opcode_reg == `SFPS_OP_WRSR) &&
                   (byte_idx_reg >= 10'd2) && (byte_idx_reg <= 10'd4);
    wire do_vwrsr = wrsr_ok && vol_arm_reg;
    wire do_nvwrsr = wrsr_ok && !vol_arm_reg && wel_reg;
    wire do_pp = frame_whole && !busy && (opcode_reg == `SFPS_OP_PP) &&
                 (byte_idx_reg > `SFPS_ADDR_FRAME) && wel_reg &&
                 !prot_hit(addr_reg);
    wire do_se = frame_whole && !busy && (opcode_reg == `SFPS_OP_SE) && is_addr &&
                 wel_reg && !prot_hit(addr_reg);
    wire do_be = frame_whole && !busy && (opcode_reg == `SFPS_OP_BE) && is_addr &&
                 wel_reg && !prot_hit(addr_reg);
    wire do_ce = frame_whole && !busy && is_op1 && wel_reg && !any_prot &&
                 ((opcode_reg == `SFPS_OP_CE1) || (opcode_reg == `SFPS_OP_CE2));

    // Shifting of opcode, address and data bytes on sampled clock rises
    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            bit_cnt_reg <= 3'd0;
            shift_reg <= 7'h00;
            byte_idx_reg <= 10'd0;
            opcode_reg <= 8'h00;
            addr_reg <= 24'h000000;
            wdata1_reg <= 8'h00;
            wdata2_reg <= 8'h00;
            wdata3_reg <= 8'h00;
            pp_cnt_reg <= 9'd0;
        end else if (cs_fall) begin
            bit_cnt_reg <= 3'd0;
            byte_idx_reg <= 10'd0;
            pp_cnt_reg <= 9'd0;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            shift_reg <= new_byte[6:0];
            if (byte_done) begin
                if (byte_idx_reg != 10'h3FF)
                    byte_idx_reg <= byte_idx_reg + 10'd1;
                case (byte_idx_reg)
                    10'd0: opcode_reg <= new_byte;
                    10'd1: begin
                        addr_reg[23:16] <= new_byte;
                        wdata1_reg <= new_byte;
                    end
                    10'd2: begin
                        addr_reg[15:8] <= new_byte;
                        wdata2_reg <= new_byte;
                    end
                    10'd3: begin
                        addr_reg[7:0] <= new_byte;
                        wdata3_reg <= new_byte;
                    end
                    default: begin
                        if (pp_cnt_reg != `SFPS_PAGE_BYTES)
                            pp_cnt_reg <= pp_cnt_reg + 9'd1;
                    end
                endcase
            end
        end
    end

    // Page buffer; the offset wraps inside the page so later bytes overwrite.
    // Offset follows the byte index, which keeps counting past a full page
    wire [7:0] pbuf_wr_ofs = addr_reg[7:0] + byte_idx_reg[7:0] - 8'h04;
    always @(posedge clock_i) begin
        if (byte_done && !busy && (opcode_reg == `SFPS_OP_PP) &&
            (byte_idx_reg >= `SFPS_ADDR_FRAME))
            pbuf_reg[pbuf_wr_ofs] <= new_byte;
    end

    // Program stream into the FIFO; its ready stalls the stream and keeps busy up
    wire [7:0] str_ofs = str_start_reg + str_idx_reg[7:0];
    wire fifo_in_valid = (state_reg == ST_STREAM);
    wire fifo_in_ready;
    wire [31:0] fifo_out;
    wire str_last = fifo_in_valid && fifo_in_ready && (str_idx_reg == str_len_reg - 9'd1);
    sfps_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i({str_page_reg, str_ofs, pbuf_reg[str_ofs]}),
        .out_valid_o(prog_valid_o),
        .out_ready_i(prog_ready_i),
        .out_data_o(fifo_out)
    );
    assign prog_addr_o = fifo_out[31:8];
    assign prog_data_o = fifo_out[7:0];

    // Sequencer: latch, status bits, self-timed cycles
    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            sr1_reg <= SR1_RST[7:2];
            sr2_reg <= SR2_RST[6:0];
            sr3_reg <= SR3_RST[6:0];
            wel_reg <= 1'b0;
            vol_arm_reg <= 1'b0;
            state_reg <= ST_IDLE;
            timer_reg <= 32'd0;
            nv_pend_reg <= 1'b0;
            pend1_reg <= 8'h00;
            pend2_reg <= 8'h00;
            pend3_reg <= 8'h00;
            str_idx_reg <= 9'd0;
            str_len_reg <= 9'd0;
            str_start_reg <= 8'h00;
            str_page_reg <= 16'h0000;
            erase_start_o <= 1'b0;
            erase_kind_o <= KIND_SECTOR;
            erase_addr_o <= 24'h000000;
        end else begin
            erase_start_o <= 1'b0;
            if (cs_rise && !busy)
                vol_arm_reg <= do_varm;
            if (do_wren)
                wel_reg <= 1'b1;
            if (do_wrdi)
                wel_reg <= 1'b0;
            if (do_vwrsr) begin
                sr1_reg <= sr1_new;
                sr2_reg <= sr2_new;
                sr3_reg <= sr3_new;
            end
            if (do_nvwrsr) begin
                pend1_reg <= {sr1_new, 2'b00};
                pend2_reg <= {1'b0, sr2_new};
                pend3_reg <= {1'b0, sr3_new};
                nv_pend_reg <= 1'b1;
                timer_reg <= STATUS_WRITE_CYC;
                state_reg <= ST_WAIT;
            end
            if (do_pp) begin
                str_idx_reg <= 9'd0;
                str_len_reg <= pp_cnt_reg;
                // Page held apart: status polls during the stream reload the address
                str_page_reg <= addr_reg[23:8];
                str_start_reg <= (pp_cnt_reg == `SFPS_PAGE_BYTES) ? 8'h00 : addr_reg[7:0];
                timer_reg <= PAGE_PROGRAM_CYC;
                state_reg <= ST_STREAM;
            end
            if (do_se || do_be || do_ce) begin
                erase_start_o <= 1'b1;
                erase_addr_o <= addr_reg;
                state_reg <= ST_WAIT;
                if (do_se) begin
                    erase_kind_o <= KIND_SECTOR;
                    timer_reg <= SECTOR_ERASE_CYC;
                end else if (do_be) begin
                    erase_kind_o <= KIND_BLOCK;
                    timer_reg <= BLOCK_ERASE_CYC;
                end else begin
                    erase_kind_o <= KIND_CHIP;
                    timer_reg <= CHIP_ERASE_CYC;
                end
            end
            // Timer runs while streaming too; busy drops only when both are done
            if (busy && timer_reg != 32'd0)
                timer_reg <= timer_reg - 32'd1;
            case (state_reg)
                ST_IDLE: begin
                end
                ST_STREAM: begin
                    if (fifo_in_ready)
                        str_idx_reg <= str_idx_reg + 9'd1;
                    if (str_last)
                        state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (timer_reg <= 32'd1) begin
                        state_reg <= ST_IDLE;
                        wel_reg <= 1'b0;
                        if (nv_pend_reg) begin
                            sr1_reg <= pend1_reg[7:2];
                            sr2_reg <= pend2_reg[6:0];
                            sr3_reg <= pend3_reg[6:0];
                            nv_pend_reg <= 1'b0;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Status one read: live value reloaded every byte, so busy can be polled
    reg rd_sr_reg;
    reg [2:0] out_cnt_reg;
    reg [6:0] out_shift_reg;
    assign so_oe_o = rd_sr_reg & ~cs_s2_reg;
    always @(posedge clock_i) begin
        if (!reset_n_i) begin
            rd_sr_reg <= 1'b0;
            out_cnt_reg <= 3'd0;
            out_shift_reg <= 7'h00;
            so_o <= 1'b0;
        end else if (cs_fall || cs_rise) begin
            rd_sr_reg <= 1'b0;
            out_cnt_reg <= 3'd0;
        end else begin
            if (byte_done && (byte_idx_reg == 10'd0) && (new_byte == `SFPS_OP_RDSR1))
                rd_sr_reg <= 1'b1;
            if (sck_fall && rd_sr_reg) begin
                out_cnt_reg <= out_cnt_reg + 3'd1;
                if (out_cnt_reg == 3'd0) begin
                    so_o <= status_reg_one_o[7];
                    out_shift_reg <= status_reg_one_o[6:0];
                end else begin
                    so_o <= out_shift_reg[6];
                    out_shift_reg <= {out_shift_reg[5:0], 1'b0};
                end
            end
        end
    end
endmodule
